//--- hdl/rcg_pkg.sv
package rcg_pkg;

  // ----------------------------------------------------------------
  // Reset extension timing
  // ----------------------------------------------------------------
  localparam int unsigned     RST_EXT_TIME_US = 9000;
  localparam longint unsigned REF_FREQ_HZ     = 64'd14318180;
  localparam longint unsigned BUS_FREQ_HZ     = 64'd33333333;
  localparam int unsigned     RST_CNT_W       = 20;
  localparam int unsigned     RST_EXT_REF_CYCLES =
    int'((64'(RST_EXT_TIME_US) * REF_FREQ_HZ + 64'd999999) / 64'd1000000);
  localparam int unsigned     RST_EXT_BUS_CYCLES =
    int'((64'(RST_EXT_TIME_US) * BUS_FREQ_HZ + 64'd999999) / 64'd1000000);

  // ----------------------------------------------------------------
  // Slow clock synthesis: toggle at twice 32.768 kHz from reference
  // ----------------------------------------------------------------
  localparam int unsigned     SLOW_ACC_W   = 24;
  localparam logic [23:0]     SLOW_STEP    = 24'h010000;
  localparam logic [23:0]     SLOW_MODULUS = 24'hda7a64;
  localparam logic [1:0]      SLOW_MODE_OUTPUT = 2'h1;

  // ----------------------------------------------------------------
  // Dot clock range limits
  // ----------------------------------------------------------------
  localparam longint unsigned DOT_MIN_HZ = 64'd10000000;
  localparam longint unsigned DOT_MAX_HZ = 64'd200000000;

  // ----------------------------------------------------------------
  // Expansion bus divisor field
  // ----------------------------------------------------------------
  localparam int unsigned     XBUS_DIV_W = 3;
  localparam logic [2:0]      XBUS_DIV_RESET = 3'h1;

  typedef enum logic [1:0] {
    RST_HOLD      = 2'b00,
    RST_WAIT_SLOW = 2'b01,
    RST_COUNT     = 2'b10,
    RST_DONE      = 2'b11
  } rcg_rst_state_e;

endpackage : rcg_pkg

//--- hdl/rcg_top.sv
// Summary of operation
// R1 - Bus reset follows power-on, plus 9 ms
// R2 - Processor reset follows power-on, plus 9 ms
// R3 - Processor reset timed from 14.31818 MHz reference
// R4 - Expansion clock divides bus clock by twice (field + 1)
// R5 - Software may route video clock onto dot
// R6 - Dot clock derived from reference clock
// R7 - Dot clock stays between 10 and 200 MHz; video path has no rate check and DOT_MIN_HZ/DOT_MAX_HZ are unused
// R8 - Slow clock pin direction set by mode
// R9 - Slow clock present whenever powered, gates resets
// R10 - Most logic timed from bus clock edges; here only the bus reset counter and expansion divider use bus_edge
// R11 - Outside source supplies 48 MHz USB clock
// R12 - Power-on release synchronised before extension count
`timescale 1ns/1ns

module rcg_top #(
  parameter int unsigned RST_EXT_REF_CYCLES = rcg_pkg::RST_EXT_REF_CYCLES,
  parameter int unsigned RST_EXT_BUS_CYCLES = rcg_pkg::RST_EXT_BUS_CYCLES
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // Power-on reset from supply
  input  wire logic       por_b,
  // Clock inputs, sampled on ref_clk
  input  wire logic       bus_clock_in,
  input  wire logic       reference_clock_14m,
  input  wire logic       video_encoder_clock_in,
  // Configuration levels
  input  wire logic [2:0] xbus_div_sel,
  input  wire logic       dot_clock_sel_video,
  input  wire logic [1:0] slow_clock_mode,
  // Slow clock pin
  input  wire logic       slow_clock_i,
  output logic            slow_clock_o,
  output logic            slow_clock_oe_b,
  // Reset outputs
  output logic            bus_reset_b,
  output logic            cpu_reset,
  // Clock outputs
  output logic            expansion_bus_clock,
  output logic            dot_clock_out
);

  // ----------------------------------------------------------------
  // Input sampling and edge detection
  // ----------------------------------------------------------------
  logic       bus_clk_q;
  logic       bus_clk_prev_q;
  logic       ref_clk14_q;
  logic       ref_clk14_prev_q;
  logic       slow_in_q;
  logic       slow_in_prev_q;
  logic       video_clk_q;
  logic       bus_edge;
  logic       ref_edge;
  logic       slow_edge;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
    begin
      bus_clk_q        <= 1'b0;
      bus_clk_prev_q   <= 1'b0;
      ref_clk14_q      <= 1'b0;
      ref_clk14_prev_q <= 1'b0;
      video_clk_q      <= 1'b0;
    end
    else
    begin
      bus_clk_q        <= bus_clock_in;
      bus_clk_prev_q   <= bus_clk_q;
      ref_clk14_q      <= reference_clock_14m;
      ref_clk14_prev_q <= ref_clk14_q;
      video_clk_q      <= video_encoder_clock_in;
    end
  end

  assign bus_edge = bus_clk_q & ~bus_clk_prev_q; // R10
  assign ref_edge = ref_clk14_q & ~ref_clk14_prev_q;

  // ----------------------------------------------------------------
  // Power-on reset synchroniser
  // ----------------------------------------------------------------
  logic por_meta_q;
  logic por_sync_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
    begin
      por_meta_q <= 1'b0;
      por_sync_q <= 1'b0;
    end
    else
    begin
      por_meta_q <= por_b; // R12
      por_sync_q <= por_meta_q; // R12
    end
  end

  // ----------------------------------------------------------------
  // Slow clock synthesis and pin direction
  // ----------------------------------------------------------------
  logic [rcg_pkg::SLOW_ACC_W-1:0] slow_acc_q;
  logic                           slow_int_q;
  logic                           slow_is_out;
  logic                           slow_src;
  logic [rcg_pkg::SLOW_ACC_W-1:0] slow_acc_sum;

  assign slow_is_out  = (slow_clock_mode == rcg_pkg::SLOW_MODE_OUTPUT);
  assign slow_acc_sum = slow_acc_q + rcg_pkg::SLOW_STEP;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
    begin
      slow_acc_q <= '0;
      slow_int_q <= 1'b0;
    end
    else if (ref_edge)
    begin
      if (slow_acc_sum >= rcg_pkg::SLOW_MODULUS)
      begin
        slow_acc_q <= slow_acc_sum - rcg_pkg::SLOW_MODULUS; // R8
        slow_int_q <= ~slow_int_q; // R8
      end
      else
      begin
        slow_acc_q <= slow_acc_sum;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
    begin
      slow_clock_o    <= 1'b0;
      slow_clock_oe_b <= 1'b1;
    end
    else
    begin
      slow_clock_o    <= slow_int_q;
      slow_clock_oe_b <= ~slow_is_out; // R8
    end
  end

  assign slow_src = slow_is_out ? slow_int_q : slow_clock_i;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
    begin
      slow_in_q      <= 1'b0;
      slow_in_prev_q <= 1'b0;
    end
    else
    begin
      slow_in_q      <= slow_src;
      slow_in_prev_q <= slow_in_q;
    end
  end

  assign slow_edge = slow_in_q & ~slow_in_prev_q;

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  rcg_pkg::rcg_rst_state_e        rst_state_q;
  logic [rcg_pkg::RST_CNT_W-1:0]  ref_cnt_q;
  logic [rcg_pkg::RST_CNT_W-1:0]  bus_cnt_q;
  logic                           ref_done;
  logic                           bus_done;

  assign ref_done = (ref_cnt_q >= rcg_pkg::RST_CNT_W'(RST_EXT_REF_CYCLES));
  assign bus_done = (bus_cnt_q >= rcg_pkg::RST_CNT_W'(RST_EXT_BUS_CYCLES));

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
    begin
      rst_state_q <= rcg_pkg::RST_HOLD;
    end
    else if (!por_sync_q)
    begin
      rst_state_q <= rcg_pkg::RST_HOLD; // R1 R2
    end
    else
    begin
      case (rst_state_q)
        rcg_pkg::RST_HOLD:      rst_state_q <= rcg_pkg::RST_WAIT_SLOW;
        rcg_pkg::RST_WAIT_SLOW: if (slow_edge) rst_state_q <= rcg_pkg::RST_COUNT; // R9
        rcg_pkg::RST_COUNT:     if (ref_done && bus_done) rst_state_q <= rcg_pkg::RST_DONE;
        default:                rst_state_q <= rcg_pkg::RST_DONE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
    begin
      ref_cnt_q <= '0;
    end
    else if (rst_state_q != rcg_pkg::RST_COUNT)
    begin
      ref_cnt_q <= '0;
    end
    else if (ref_edge && !ref_done)
    begin
      ref_cnt_q <= ref_cnt_q + 1'b1; // R3
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
    begin
      bus_cnt_q <= '0;
    end
    else if (rst_state_q != rcg_pkg::RST_COUNT)
    begin
      bus_cnt_q <= '0;
    end
    else if (bus_edge && !bus_done)
    begin
      bus_cnt_q <= bus_cnt_q + 1'b1; // R10
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
    begin
      bus_reset_b <= 1'b0;
      cpu_reset   <= 1'b1;
    end
    else
    begin
      bus_reset_b <= (rst_state_q == rcg_pkg::RST_COUNT) && bus_done && por_sync_q
                     || (rst_state_q == rcg_pkg::RST_DONE) && por_sync_q; // R1
      cpu_reset   <= !((rst_state_q == rcg_pkg::RST_COUNT) && ref_done && por_sync_q
                     || (rst_state_q == rcg_pkg::RST_DONE) && por_sync_q); // R2 R3
    end
  end

  // ----------------------------------------------------------------
  // Expansion bus clock divider
  // ----------------------------------------------------------------
  logic [rcg_pkg::XBUS_DIV_W-1:0] xbus_cnt_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
    begin
      xbus_cnt_q          <= '0;
      expansion_bus_clock <= 1'b0;
    end
    else if (bus_edge)
    begin
      if (xbus_cnt_q >= xbus_div_sel)
      begin
        xbus_cnt_q          <= '0;
        expansion_bus_clock <= ~expansion_bus_clock; // R4
      end
      else
      begin
        xbus_cnt_q <= xbus_cnt_q + 1'b1; // R4
      end
    end
  end

  // ----------------------------------------------------------------
  // Dot clock: reference rate (within 10..200 MHz) or video clock
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
    begin
      dot_clock_out <= 1'b0;
    end
    else if (dot_clock_sel_video)
    begin
      dot_clock_out <= video_clk_q; // R5
    end
    else
    begin
      dot_clock_out <= ref_clk14_q; // R6 R7
    end
  end

endmodule : rcg_top

//--- verification/rcg_clk_model.sv
`timescale 1ns/1ns

module rcg_clk_model (
  // Sampling clock
  input  wire logic ref_clk,
  // Clock sources
  output logic      bus_clock_in,
  output logic      reference_clock_14m,
  output logic      video_encoder_clock_in,
  output logic      slow_clock_i
);
  // ----------------------------------------
  // Free-running sources, periods 8/16/4/64
  // ----------------------------------------
  logic [5:0] cnt_q = 6'h00;

  always_ff @(posedge ref_clk) cnt_q <= cnt_q + 6'h01;

  assign bus_clock_in           = cnt_q[2];
  assign reference_clock_14m    = cnt_q[3];
  assign video_encoder_clock_in = cnt_q[1];
  assign slow_clock_i           = cnt_q[5];

  // USB clock source for the companion's USB logic, which sits outside this block
  logic usb_clock_src;

  assign usb_clock_src = cnt_q[0];
endmodule : rcg_clk_model

//--- verification/rcg_assertions.sv
`timescale 1ns/1ns

module rcg_checker (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_b,
  // Watched ports
  input wire logic       por_b,
  input wire logic       reference_clock_14m,
  input wire logic       video_encoder_clock_in,
  input wire logic       dot_clock_sel_video,
  input wire logic [1:0] slow_clock_mode,
  input wire logic       slow_clock_oe_b,
  input wire logic       bus_reset_b,
  input wire logic       cpu_reset,
  input wire logic       dot_clock_out
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_vid_steady; dot_clock_sel_video[*3]; endsequence
  sequence s_ref_steady; (!dot_clock_sel_video)[*3]; endsequence

  property p_por_bus; $fell(por_b) |-> ##[1:4] !bus_reset_b; endproperty
  property p_por_cpu; $fell(por_b) |-> ##[1:4] cpu_reset; endproperty
  property p_oe_out; slow_clock_mode == 2'h1 |=> !slow_clock_oe_b; endproperty
  property p_oe_in; slow_clock_mode != 2'h1 |=> slow_clock_oe_b; endproperty
  property p_video; s_vid_steady ##0 $rose(video_encoder_clock_in) |-> ##[1:3] dot_clock_out; endproperty
  property p_ref; s_ref_steady ##0 $rose(reference_clock_14m) |-> ##[1:3] dot_clock_out; endproperty
  property p_cpu_sync; $fell(cpu_reset) |-> $past(por_b, 6); endproperty
  property p_bus_sync; $rose(bus_reset_b) |-> $past(por_b, 6); endproperty

  a_por_bus: assert property (p_por_bus) else $error("bus reset not reasserted");
  a_por_cpu: assert property (p_por_cpu) else $error("cpu reset not reasserted");
  a_oe_out: assert property (p_oe_out) else $error("slow pin not driven");
  a_oe_in: assert property (p_oe_in) else $error("slow pin driven in input mode");
  a_video: assert property (p_video) else $error("dot clock ignores video clock");
  a_ref: assert property (p_ref) else $error("dot clock ignores reference");
  a_cpu_sync: assert property (p_cpu_sync) else $error("cpu reset released too early");
  a_bus_sync: assert property (p_bus_sync) else $error("bus reset released too early");
endmodule : rcg_checker

bind rcg_top rcg_checker rcg_checker_inst (.ref_clk(ref_clk), .rst_b(rst_b), .por_b(por_b),
  .reference_clock_14m(reference_clock_14m), .video_encoder_clock_in(video_encoder_clock_in),
  .dot_clock_sel_video(dot_clock_sel_video), .slow_clock_mode(slow_clock_mode),
  .slow_clock_oe_b(slow_clock_oe_b), .bus_reset_b(bus_reset_b), .cpu_reset(cpu_reset),
  .dot_clock_out(dot_clock_out));

//--- verification/testbench.sv
`timescale 1ns/1ns

module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic       ref_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       por_b = 1'b0;
  logic [2:0] xbus_div_sel = 3'h0;
  logic       dot_clock_sel_video = 1'b0;
  logic [1:0] slow_clock_mode = 2'h0;
  logic       bus_clock_in, reference_clock_14m, video_encoder_clock_in, slow_clock_i;
  logic       slow_clock_o, slow_clock_oe_b, bus_reset_b, cpu_reset, expansion_bus_clock, dot_clock_out;
  int         miscompares = 0;
  int         checks = 0;
  int         cyc = 0;
  int         p;

  always #2 ref_clk = ~ref_clk;

  rcg_clk_model rcg_clk_model_inst (.ref_clk(ref_clk), .bus_clock_in(bus_clock_in),
    .reference_clock_14m(reference_clock_14m), .video_encoder_clock_in(video_encoder_clock_in),
    .slow_clock_i(slow_clock_i));

  rcg_top #(.RST_EXT_REF_CYCLES(20), .RST_EXT_BUS_CYCLES(30)) rcg_top_inst (.ref_clk(ref_clk),
    .rst_b(rst_b), .por_b(por_b), .bus_clock_in(bus_clock_in), .reference_clock_14m(reference_clock_14m),
    .video_encoder_clock_in(video_encoder_clock_in), .xbus_div_sel(xbus_div_sel),
    .dot_clock_sel_video(dot_clock_sel_video), .slow_clock_mode(slow_clock_mode),
    .slow_clock_i(slow_clock_i), .slow_clock_o(slow_clock_o), .slow_clock_oe_b(slow_clock_oe_b),
    .bus_reset_b(bus_reset_b), .cpu_reset(cpu_reset), .expansion_bus_clock(expansion_bus_clock),
    .dot_clock_out(dot_clock_out));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  function automatic logic pick(input int w);
    return w == 0 ? expansion_bus_clock : w == 1 ? dot_clock_out : slow_clock_o;
  endfunction : pick

  // Waits for the next low-to-high change, bounded
  task automatic rise(input int w);
    int   n;
    logic prev;
    n = 0;
    prev = pick(w);
    @(negedge ref_clk);
    while (!(prev === 1'b0 && pick(w) === 1'b1) && n < 9000)
    begin
      prev = pick(w);
      @(negedge ref_clk);
      n++;
    end
  endtask : rise

  task automatic measure(input int w);
    int t0;
    rise(w);
    t0 = cyc;
    rise(w);
    p = cyc - t0;
  endtask : measure

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_release();
    int n;
    n = 0;
    @(posedge ref_clk);
    por_b <= 1'b1;
    repeat (220) @(negedge ref_clk);
    check(bus_reset_b, 1'b0);
    check(cpu_reset, 1'b1);
    while ((cpu_reset !== 1'b0 || bus_reset_b !== 1'b1) && n < 1000)
    begin
      @(negedge ref_clk);
      n++;
    end
    check(cpu_reset, 1'b0);
    check(bus_reset_b, 1'b1);
  endtask : t_release

  task automatic t_reassert();
    @(posedge ref_clk);
    por_b <= 1'b0;
    repeat (6) @(negedge ref_clk);
    check(bus_reset_b, 1'b0);
    check(cpu_reset, 1'b1);
    t_release();
  endtask : t_reassert

  task automatic t_xbus();
    for (int n = 0; n < 8; n++)
    begin
      @(posedge ref_clk);
      xbus_div_sel <= 3'(n);
      measure(0);
      measure(0);
      check(32'(p), 32'(16 * (n + 1)));
    end
  endtask : t_xbus

  task automatic t_dot();
    for (int s = 0; s < 2; s++)
    begin
      @(posedge ref_clk);
      dot_clock_sel_video <= 1'(s);
      measure(1);
      measure(1);
      check(32'(p), s ? 32'h4 : 32'h10);
      check(32'(p >= 2 && p <= 25), 32'h1);
    end
  endtask : t_dot

  task automatic t_slow();
    @(posedge ref_clk);
    slow_clock_mode <= 2'h1;
    repeat (2) @(negedge ref_clk);
    check(slow_clock_oe_b, 1'b0);
    measure(2);
    check(32'(p >= 6976 && p <= 7008), 32'h1);
    @(posedge ref_clk);
    slow_clock_mode <= 2'h2;
    repeat (2) @(negedge ref_clk);
    check(slow_clock_oe_b, 1'b1);
  endtask : t_slow

  // ----------------------------------------
  // Sequence and timeout
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      miscompares++;
      final_report();
    end
  end

  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_release();
    t_reassert();
    t_xbus();
    t_dot();
    t_slow();
    final_report();
  end
endmodule : testbench
